// ### mgd_defines.vh
`ifndef MGD_DEFINES_VH
`define MGD_DEFINES_VH

// Opcode match patterns
`define MGD_PAGE_LOAD_TOP 15'h3700
`define MGD_ADD_PRODUCT_OP 16'h7F8F
`define MGD_LOAD_ACC_BYTE 8'h6C
`define MGD_LOAD_ACC_MOVE_BYTE 8'h6B
`define MGD_LOAD_T_BYTE 8'h6A
`define MGD_MUL_MEM_BYTE 8'h6D
`define MGD_MUL_CONST_TOP 3'h4

// Field positions
`define MGD_CONST_MSB 12

// Reset values
`define MGD_ACC_RESET 32'h00000000
`define MGD_PROD_RESET 32'h00000000
`define MGD_T_RESET 16'h0000
`define MGD_PAGE_RESET 1'h0

`endif

// ### mgd_multiply_group_decoder.v
// Function
// RQ1: Page pointer immediate load takes opcode bit zero
// RQ2: Fixed opcode adds product to accumulator
// RQ3: Load multiplicand, accumulate previous product
// RQ4: Load multiplicand, accumulate, request data move
// RQ5: Multiply multiplicand by memory word into product
// RQ6: Multiply multiplicand by 13-bit immediate constant
`timescale 1ns/1ps
`include "mgd_defines.vh"

module mgd_multiply_group_decoder (
    input wire clk,
    input wire resetn,
    input wire opValid,
    input wire [15:0] opcode,
    input wire [15:0] memData,
    output reg [31:0] accumulator,
    output reg [31:0] product,
    output reg [15:0] multiplicand,
    output reg pagePointer,
    output reg dataMove,
    output reg [6:0] moveAddr,
    output wire opTaken
);

    // Decoded instruction strobes, one hot for legal opcodes
    wire isPageLoad; // Page pointer immediate load
    wire isAddProduct; // Add product to accumulator
    wire isLoadAcc; // Multiplicand load with accumulate
    wire isLoadAccMove; // Same, plus a data move request
    wire isLoadT; // Plain multiplicand load
    wire isMulMem; // Multiply by the memory operand
    wire isMulConst; // Multiply by the immediate constant
    // Groupings shared by several register selects
    wire isAccumulate; // Any form that adds the product
    wire isTLoad; // Any form that loads the multiplicand
    wire isMultiply; // Any form that writes the product
    // Upper opcode byte, the key for most of the group
    wire [7:0] opByte;
    // Sign-extended immediate and products
    wire [15:0] constExt;
    wire signed [31:0] memProduct;
    wire signed [31:0] constProduct;
    // Sum with carry kept, so the cut to 32 bits is explicit
    wire [32:0] accSum;
    // Accumulate uses the product as it stood before this word
    wire [31:0] accPlusProduct;
    // Next values of every architectural register
    reg [31:0] next_accumulator; // Accumulator after this word
    reg [31:0] next_product; // Product register after this word
    reg [15:0] next_multiplicand; // Multiplicand after this word
    reg next_pagePointer; // Page pointer after this word
    reg next_dataMove; // Move pulse for the next cycle
    reg [6:0] next_moveAddr; // Move address after this word

    // Upper byte pulled out once for the byte-keyed forms
    assign opByte = opcode[15:8];

    // Opcode pattern matching, all gated by a valid word
    assign isPageLoad = opValid &&
        (opcode[15:1] == `MGD_PAGE_LOAD_TOP); // RQ1
    assign isAddProduct = opValid &&
        (opcode == `MGD_ADD_PRODUCT_OP); // RQ2
    assign isLoadAcc = opValid &&
        (opByte == `MGD_LOAD_ACC_BYTE); // RQ3
    assign isLoadAccMove = opValid &&
        (opByte == `MGD_LOAD_ACC_MOVE_BYTE); // RQ4
    // Plain load kept in the group, it shares the load path
    assign isLoadT = opValid &&
        (opByte == `MGD_LOAD_T_BYTE);
    assign isMulMem = opValid &&
        (opByte == `MGD_MUL_MEM_BYTE); // RQ5
    assign isMulConst = opValid &&
        (opcode[15:13] == `MGD_MUL_CONST_TOP); // RQ6

    // Group strobes; the patterns never overlap, so no priority
    assign isAccumulate = isAddProduct || isLoadAcc || isLoadAccMove;
    assign isTLoad = isLoadAcc || isLoadAccMove || isLoadT;
    assign isMultiply = isMulMem || isMulConst;

    // Immediate is 13 bits, sign extended to multiplicand width
    assign constExt = {{3{opcode[`MGD_CONST_MSB]}},
        opcode[`MGD_CONST_MSB:0]};

    // Signed 16 by 16 products fill exactly 32 bits
    assign memProduct = $signed(multiplicand) * $signed(memData);
    assign constProduct = $signed(multiplicand) * $signed(constExt);

    // Wraparound add; there is no overflow mode in this block
    assign accSum = {1'b0, accumulator} + {1'b0, product};
    assign accPlusProduct = accSum[31:0];

    // Every decoded word completes in one cycle, so none stalls fetch
    assign opTaken = opValid;

    // Next accumulator: only the accumulate forms touch it
    always @*
    begin
        next_accumulator = accumulator;
        // Old product is read, a multiply cannot share this word
        if (isAccumulate)
        begin
            next_accumulator = accPlusProduct; // RQ2
        end
    end

    // Next product: the two multiply forms write it
    always @*
    begin
        next_product = product;
        // Memory operand form
        if (isMulMem)
        begin
            next_product = memProduct; // RQ5
        end
        // Immediate constant form
        else if (isMulConst)
        begin
            next_product = constProduct; // RQ6
        end
    end

    // Next multiplicand: loaded from the addressed word
    always @*
    begin
        next_multiplicand = multiplicand;
        // Accumulating loads still take the word in the same cycle
        if (isTLoad)
        begin
            next_multiplicand = memData; // RQ3
        end
    end

    // Next page pointer: only the lowest opcode bit is kept
    always @*
    begin
        next_pagePointer = pagePointer;
        // Other bits of the word are fixed by the pattern
        if (isPageLoad)
        begin
            next_pagePointer = opcode[0]; // RQ1
        end
    end

    // Next move request and its address
    always @*
    begin
        // Pulse lasts one cycle; memory side does the move itself
        next_dataMove = isLoadAccMove; // RQ4
        next_moveAddr = moveAddr;
        // Address holds after the pulse for a late reader
        if (isLoadAccMove)
        begin
            next_moveAddr = opcode[6:0];
        end
    end

    // Accumulator register
    always @(posedge clk)
    begin
        // Synchronous reset to the cleared state
        if (!resetn)
        begin
            accumulator <= `MGD_ACC_RESET;
        end
        else
        begin
            accumulator <= next_accumulator; // RQ3
        end
    end

    // Product register
    always @(posedge clk)
    begin
        // Synchronous reset to the cleared state
        if (!resetn)
        begin
            product <= `MGD_PROD_RESET;
        end
        else
        begin
            product <= next_product;
        end
    end

    // Multiplicand register
    always @(posedge clk)
    begin
        // Synchronous reset to the cleared state
        if (!resetn)
        begin
            multiplicand <= `MGD_T_RESET;
        end
        else
        begin
            multiplicand <= next_multiplicand; // RQ4
        end
    end

    // Page pointer register
    always @(posedge clk)
    begin
        // Synchronous reset to the cleared state
        if (!resetn)
        begin
            pagePointer <= `MGD_PAGE_RESET;
        end
        else
        begin
            pagePointer <= next_pagePointer;
        end
    end

    // Move request pulse and address registers
    always @(posedge clk)
    begin
        // No move may be requested while in reset
        if (!resetn)
        begin
            dataMove <= 1'b0;
            moveAddr <= 7'h00;
        end
        else
        begin
            dataMove <= next_dataMove;
            moveAddr <= next_moveAddr;
        end
    end

endmodule // mgd_multiply_group_decoder

// ### mgd_props.sv
`timescale 1ns/1ps
module mgd_props(input clk,resetn,opValid,dataMove,pagePointer,
input [15:0] opcode,memData,multiplicand,input [31:0] accumulator,product);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
// Signed operands; an idle word reads as zero and matches nothing
wire signed [31:0] t=$signed(multiplicand),m=$signed(memData),
k=$signed(opcode[12:0]),s=accumulator+product;
wire [15:0] o=opValid?opcode:16'h0;
property p_pg;o[15:1]==15'h3700|=>pagePointer==$past(o[0]);endproperty
a_pg:assert property(p_pg)else $error("page");
property p_ad;o==16'h7F8F|=>accumulator==$past(s);endproperty
a_ad:assert property(p_ad)else $error("add");
property p_la;o[15:8]==8'h6C|=>accumulator==$past(s);endproperty
a_la:assert property(p_la)else $error("load");
property p_lm;o[15:8]==8'h6B|=>dataMove&&accumulator==$past(s);endproperty
a_lm:assert property(p_lm)else $error("move");
property p_mm;o[15:8]==8'h6D|=>product==$past(t)*$past(m);endproperty
a_mm:assert property(p_mm)else $error("mul");
property p_mk;o[15:13]==3'h4|=>product==$past(t)*$past(k);endproperty
a_mk:assert property(p_mk)else $error("imm");
property p_lt;o[15:8]==8'h6C|=>multiplicand==$past(memData);endproperty
a_lt:assert property(p_lt)else $error("mcand");
cover property(o[15:8]==8'h6D);
cover property(dataMove);
cover property(pagePointer);
cover property(o[15]);
endmodule // mgd_props

// ### mgd_fetch.sv
`timescale 1ns/1ps
module mgd_fetch(input clk,resetn,output reg opValid,
output reg [15:0] opcode,memData);
integer seed=58179;
integer n=0;
reg [31:0] r;
initial {opValid,opcode,memData}=33'h0;
// Hand-written corner words, memory word above the opcode
function [31:0] corner(input [3:0] i);
case (i)
4'h0: corner=32'h80006A00;
4'h1: corner=32'h80006D00;
4'h2: corner=32'h00007F8F;
4'h3: corner=32'h00009FFF;
4'h4: corner=32'h7FFF6C05;
4'h5: corner=32'h00008FFF;
4'h6: corner=32'h00016B7F;
4'h7: corner=32'h00006E01;
default: corner=32'h00006E00;
endcase
endfunction
// Delayed NBA samples reset at the edge, so no race with the bench
always @(posedge clk) begin r=$random(seed);
if (resetn&&n<9) begin {memData,opcode}<=#1 corner(n[3:0]);
opValid<=#1 1'b1; n=n+1; end else begin
opValid<=#1 resetn&&r[18:16]!=3'h0;
memData<=#1 r[31:16];
opcode<=#1 r[15]?(r[14]?{5'h0D,r[2:0],r[10:3]}:{3'h4,r[12:0]}):
(r[14]?{15'h3700,r[0]}:16'h7F8F); end end
endmodule // mgd_fetch

// ### test_multiply_group_decoder.sv
`timescale 1ns/1ps
module test_multiply_group_decoder;
reg clk=0,resetn=0;
wire opValid,dataMove,pagePointer,opTaken;
wire [15:0] opcode,memData,multiplicand;
wire [31:0] accumulator,product;
wire [6:0] moveAddr;
// Expected multiplicand, accumulator, product and flag word
reg [15:0] t;
reg [31:0] a,p;
reg [8:0] x;
integer n_fail=0,num_checks=0;
wire [7:0] h=opcode[15:8];
mgd_fetch i_fetch(.*);
mgd_multiply_group_decoder i_dut(.*);
initial forever #4 clk=~clk;
// Signed 16 by 16 product as the multiply rules define it
function [31:0] mul(input [15:0] u,v);
mul=$signed(u)*$signed(v);
endfunction
// 13-bit immediate widened with its sign
function [15:0] sx(input [12:0] k);
sx={{3{k[12]}},k};
endfunction
// Model: accumulate reads the old product, multiply the old operand
always @(posedge clk) begin x[7]=1'b0;
if (!resetn) begin t=16'h0; a=32'h0; p=32'h0; x=9'h000; end
else if (opValid) begin
if (opcode[15:1]==15'h3700) x[8]=opcode[0];
if (opcode==16'h7F8F||h==8'h6B||h==8'h6C) a=a+p;
if (h==8'h6D) p=mul(t,memData);
if (opcode[15:13]==3'h4) p=mul(t,sx(opcode[12:0]));
if (h>8'h69&&h<8'h6D) t=memData;
if (h==8'h6B) x[7:0]={1'b1,opcode[6:0]}; end end
always @(negedge clk) if (resetn) begin
chk("t",{16'h0,t},{16'h0,multiplicand});
chk("acc",a,accumulator);
chk("prod",p,product);
chkf("pgmv",x,{pagePointer,dataMove,moveAddr});
chkf("take",{8'h00,opValid},{8'h00,opTaken});
end
// Register values
task chk(input [31:0] n,e,g); begin num_checks=num_checks+1;
if (e!==g) begin n_fail=n_fail+1;
$display("BAD %0s %h %h",n,e,g); end end endtask
// Control bits and the move address
task chkf(input [31:0] n,input [8:0] e,g); begin
num_checks=num_checks+1;
if (e!==g) begin n_fail=n_fail+1;
$display("BAD %0s %h %h",n,e,g); end end endtask
task finish_test; $display("%0d checks %0d bad",num_checks,n_fail);
if (n_fail==0&&num_checks>0) $display("Test passed");
else $display("Test failed");
$finish; endtask
initial begin repeat (16) @(posedge clk); #1 resetn=1;
repeat (4000) @(posedge clk); $display("run done"); finish_test; end
endmodule // test_multiply_group_decoder
bind mgd_multiply_group_decoder mgd_props i_props(.*);
